// >>> rtl/lsf_fault_response.sv
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
module lsf_fault_response
	import lsf_pkg::*;
#(
	parameter int PERSIST = PERSIST_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        clkEn,
	input  wire logic [7:0]  avsAddress,
	input  wire logic        avsRead,
	input  wire logic        avsWrite,
	input  wire logic [31:0] avsWriteData,
	input  wire logic [3:0]  avsByteEnable,
	output logic [31:0]      avsReadData,
	output logic             avsWaitRequest,
	input  wire logic        overcurrentRaw,
	input  wire logic        otherSupplyFault,
	output logic             switchOn,
	output logic             shutdownReq,
	output logic             overcurrentTopIrq,
	output logic             supplyFaultN
);
	typedef struct packed {
		logic [2:0]  syncOc;
		logic [2:0]  syncOther;
		logic        ocStable;
		logic        otherStable;
		logic        qualPrev;
		logic        ocFlag;
		logic        ocFlagMask;
		logic [15:0] control;
		logic        swEnable;
		logic        pinMask;
		lsf_bus_type bus;
		logic [31:0] rdata;
		logic        waitReq;
		logic        switchOut;
		logic        shutdown;
		logic        irq;
		logic        faultN;
	} lsf_main_type;
	lsf_main_type state_r;
	lsf_main_type state_nxt;
	logic         qualified;

	lsf_persist #(
		.COUNT (PERSIST)
	) u_persist (
		.clk       (clk),
		.reset     (reset),
		.clkEn     (clkEn),
		.rawIn     (state_r.ocStable),
		.qualified (qualified)
	);

	logic [15:0] wData;
	logic [15:0] wMask;
	logic        qualRise;
	logic [1:0]  action;
	assign wData    = avsWriteData[15:0];
	assign wMask    = {{8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
	assign qualRise = qualified && !state_r.qualPrev;
	assign action   = state_r.control[ACT_HI:ACT_LO];

	always_comb
	begin
		state_nxt = state_r;
		// Three stage sync, change accepted once stages two and three agree
		state_nxt.syncOc    = {state_r.syncOc[1:0], overcurrentRaw};
		state_nxt.syncOther = {state_r.syncOther[1:0], otherSupplyFault};
		if (state_r.syncOc[2] == state_r.syncOc[1])
			state_nxt.ocStable = state_r.syncOc[2];
		if (state_r.syncOther[2] == state_r.syncOther[1])
			state_nxt.otherStable = state_r.syncOther[2];
		state_nxt.qualPrev = qualified;
		state_nxt.waitReq  = 1'b1;
		state_nxt.rdata    = state_r.rdata;

		// One wait cycle, answer in the second
		case (state_r.bus)
			BUS_IDLE:
			begin
				if (avsRead || avsWrite)
				begin
					state_nxt.bus     = BUS_ACK;
					state_nxt.waitReq = 1'b0;
					state_nxt.rdata   = UNMAPPED_DATA;
					if (avsRead)
					begin
						if (avsAddress == OFS_IRQ_STATUS)
						begin
							state_nxt.rdata[BIT_OC] = state_r.ocFlag;
							state_nxt.ocFlag = 1'b0;
						end
						else if (avsAddress == OFS_IRQ_MASK)
							state_nxt.rdata[BIT_OC] = state_r.ocFlagMask;
						else if (avsAddress == OFS_SW_CONTROL)
							state_nxt.rdata[15:0] = state_r.control;
						else if (avsAddress == OFS_SW_ENABLE)
							state_nxt.rdata[BIT_ENABLE] = state_r.swEnable;
						else if (avsAddress == OFS_FAULT_MASK)
							state_nxt.rdata[BIT_OC] = state_r.pinMask;
					end
					else
					begin
						if (avsAddress == OFS_IRQ_MASK && avsByteEnable[1])
							state_nxt.ocFlagMask = wData[BIT_OC];
						else if (avsAddress == OFS_SW_CONTROL)
							state_nxt.control = (state_r.control & ~(wMask
								& CTRL_WR_MASK)) | (wData & wMask & CTRL_WR_MASK);
						else if (avsAddress == OFS_FAULT_MASK && avsByteEnable[1])
							state_nxt.pinMask = wData[BIT_OC];
						else if (avsAddress == OFS_SW_ENABLE && avsByteEnable[1])
							state_nxt.swEnable = wData[BIT_ENABLE];
					end
				end
			end
			BUS_ACK:
				state_nxt.bus = BUS_IDLE;
			default:
				state_nxt.bus = BUS_IDLE;
		endcase

		// set on rising edge, wins over read clear
		if (qualRise)
			state_nxt.ocFlag = 1'b1;

		if (qualRise && action != ACT_IGNORE)
		begin
			if (action == ACT_OPEN)
				state_nxt.swEnable = 1'b0;
			else
				state_nxt.shutdown = 1'b1;
		end

		// Enable kept apart from the response field so they never alias
		// enable drives switch
		state_nxt.switchOut = state_nxt.swEnable;
		state_nxt.irq = state_nxt.ocFlag && !state_nxt.ocFlagMask;
		state_nxt.faultN = !(state_r.otherStable
			|| (qualified && !state_nxt.pinMask));
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r            <= '0;
			state_r.control    <= RST_CONTROL;
			state_r.swEnable   <= RST_SW_ENABLE[BIT_ENABLE];
			state_r.ocFlagMask <= RST_IRQ_MASK[BIT_OC];
			state_r.pinMask    <= RST_FAULT_MASK[BIT_OC];
			state_r.bus        <= BUS_IDLE;
			state_r.waitReq    <= 1'b1;
			state_r.faultN     <= 1'b1;
		end
		else if (clkEn)
			state_r <= state_nxt;
	end

	assign avsReadData       = state_r.rdata;
	assign avsWaitRequest    = state_r.waitReq;
	assign switchOn          = state_r.switchOut;
	assign shutdownReq       = state_r.shutdown;
	assign overcurrentTopIrq = state_r.irq;
	assign supplyFaultN      = state_r.faultN;

	sequence s_rise;
		clkEn && qualified && !state_r.qualPrev;
	endsequence

	sequence s_status_read;
		clkEn && state_r.bus == BUS_IDLE && avsRead
			&& avsAddress == OFS_IRQ_STATUS;
	endsequence

	property p_flag_set;
		@(posedge clk) disable iff (reset)
		s_rise |=> state_r.ocFlag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("status not set on qualified rise");

	property p_read_clear;
		@(posedge clk) disable iff (reset)
		clkEn && state_r.bus == BUS_IDLE && avsRead
			&& avsAddress == OFS_IRQ_STATUS && !qualRise |=> !state_r.ocFlag;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status not cleared by read");

	property p_mask;
		@(posedge clk) disable iff (reset)
		state_r.ocFlagMask && $past(state_r.ocFlagMask) && $past(clkEn)
			|-> !state_r.irq;
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked flag raised interrupt");

	property p_irq;
		@(posedge clk) disable iff (reset)
		clkEn |=> state_r.irq == (state_r.ocFlag && !state_r.ocFlagMask);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not status and not mask");

	property p_open;
		@(posedge clk) disable iff (reset)
		(s_rise and (action == ACT_OPEN)) |=> !state_r.switchOut;
	endproperty
	a_open: assert property (p_open)
		else $error("switch not opened by fault");

	property p_shutdown;
		@(posedge clk) disable iff (reset)
		(s_rise and (action[1] == 1'b1)) |=> state_r.shutdown;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown not requested");

	property p_pin;
		@(posedge clk) disable iff (reset)
		clkEn && qualified && !state_r.pinMask && !avsWrite |=> !supplyFaultN;
	endproperty
	a_pin: assert property (p_pin)
		else $error("fault pin not low on fault");

	property p_pin_mask;
		@(posedge clk) disable iff (reset)
		clkEn && state_r.pinMask && !state_r.otherStable && !avsWrite
			|=> supplyFaultN;
	endproperty
	a_pin_mask: assert property (p_pin_mask)
		else $error("masked switch drove fault pin");

	property p_enable;
		@(posedge clk) disable iff (reset)
		clkEn |=> switchOn == state_r.swEnable;
	endproperty
	a_enable: assert property (p_enable)
		else $error("switch output differs from enable");

	// Read answer carries the flag as it stood when taken
	property p_status_answer;
		@(posedge clk) disable iff (reset)
		s_status_read |=> !avsWaitRequest
			&& avsReadData[BIT_OC] == $past(state_r.ocFlag);
	endproperty
	a_status_answer: assert property (p_status_answer)
		else $error("status read answered wrongly");

	// Answer stands one cycle only, so a held read is not cleared twice
	property p_status_release;
		@(posedge clk) disable iff (reset)
		s_status_read ##1 clkEn |=> avsWaitRequest;
	endproperty
	a_status_release: assert property (p_status_release)
		else $error("wait request stayed low");

	// Sticky until software reads it
	property p_flag_hold;
		@(posedge clk) disable iff (reset)
		state_r.ocFlag && !(clkEn && state_r.bus == BUS_IDLE && avsRead
			&& avsAddress == OFS_IRQ_STATUS) |=> state_r.ocFlag;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("status bit lost without a read");

	// A level that stays high must not set the bit again
	property p_flag_edge;
		@(posedge clk) disable iff (reset)
		$rose(state_r.ocFlag) |-> $past(qualRise) && $past(clkEn);
	endproperty
	a_flag_edge: assert property (p_flag_edge)
		else $error("status bit set without a rising edge");

	// Latched until reset; software cannot withdraw it
	property p_shut_hold;
		@(posedge clk) disable iff (reset)
		state_r.shutdown |=> state_r.shutdown;
	endproperty
	a_shut_hold: assert property (p_shut_hold)
		else $error("shutdown request dropped");

	property p_shut_cause;
		@(posedge clk) disable iff (reset)
		$rose(state_r.shutdown) |-> $past(qualRise) && $past(action[1]);
	endproperty
	a_shut_cause: assert property (p_shut_cause)
		else $error("shutdown without a fault");

	// A write in the same cycle may legally move the enable
	property p_ignore;
		@(posedge clk) disable iff (reset)
		(s_rise and (action == ACT_IGNORE && !avsWrite))
			|=> $stable(state_r.shutdown) && $stable(state_r.swEnable);
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("ignored fault changed the switch");

	property p_pin_other;
		@(posedge clk) disable iff (reset)
		clkEn && state_r.otherStable |=> !supplyFaultN;
	endproperty
	a_pin_other: assert property (p_pin_other)
		else $error("fault pin high on other fault");

	// High whenever no source reports a fault
	property p_pin_high;
		@(posedge clk) disable iff (reset)
		clkEn && !state_r.otherStable && !qualified |=> supplyFaultN;
	endproperty
	a_pin_high: assert property (p_pin_high)
		else $error("fault pin low with no fault");

	// A fault edge in the same cycle overrides the write when the response is open
	property p_enable_write;
		@(posedge clk) disable iff (reset)
		clkEn && state_r.bus == BUS_IDLE && avsWrite && !qualRise
			&& avsAddress == OFS_SW_ENABLE && avsByteEnable[1]
			|=> state_r.swEnable == $past(avsWriteData[BIT_ENABLE]);
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("enable write not taken");

	// Only software may close the switch again after an open response
	property p_reenable;
		@(posedge clk) disable iff (reset)
		$rose(state_r.swEnable) |-> $past(avsWrite)
			&& $past(avsAddress) == OFS_SW_ENABLE;
	endproperty
	a_reenable: assert property (p_reenable)
		else $error("switch enabled without a write");
endmodule : lsf_fault_response

// >>> rtl/lsf_pkg.sv
package lsf_pkg;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h1D;
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h25;
	localparam logic [7:0]  OFS_SW_CONTROL  = 8'hC7;
	localparam logic [7:0]  OFS_FAULT_MASK  = 8'hD7;
	localparam logic [7:0]  OFS_SW_ENABLE   = 8'h0D;
	localparam int          BIT_OC          = 15;
	localparam int          BIT_ENABLE      = 15;
	localparam int          ACT_HI          = 15;
	localparam int          ACT_LO          = 14;
	localparam logic [1:0]  ACT_IGNORE      = 2'h0;
	localparam logic [1:0]  ACT_OPEN        = 2'h1;
	localparam logic [15:0] RST_CONTROL     = 16'h0003;
	localparam logic [15:0] RST_IRQ_MASK    = 16'h0000;
	localparam logic [15:0] RST_FAULT_MASK  = 16'h0000;
	localparam logic [15:0] RST_SW_ENABLE   = 16'h0000;
	localparam logic [15:0] CTRL_WR_MASK    = 16'hFFD3;
	localparam int          PERSIST_CYCLES  = 16;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
	typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} lsf_bus_type;
endpackage : lsf_pkg

// >>> rtl/lsf_persist.sv
`timescale 1ns/100ps
module lsf_persist
	import lsf_pkg::*;
#(
	parameter int COUNT = PERSIST_CYCLES
)
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clkEn,
	input  wire logic rawIn,
	output logic      qualified
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        q;
	} lsf_persist_type;
	lsf_persist_type state_r;
	lsf_persist_type state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		if (!rawIn)
		begin
			state_nxt.cnt = 16'h0000;
			state_nxt.q   = 1'b0;
		end
		else if (state_r.cnt < 16'(COUNT - 1))
			state_nxt.cnt = state_r.cnt + 16'h0001;
		else
			state_nxt.q = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_r <= '0;
		else if (clkEn)
			state_r <= state_nxt;
	end

	assign qualified = state_r.q;

	property p_persist;
		@(posedge clk) disable iff (reset)
		$rose(state_r.q) |-> $past(rawIn) && $past(state_r.cnt) == 16'(COUNT - 1);
	endproperty
	a_persist: assert property (p_persist)
		else $error("qualified rose without full persistence");
endmodule : lsf_persist

// >>> tb/lsf_oc_source.sv
`timescale 1ns/100ps
// Over-current detector model: holds its line high for pulseLen cycles
module lsf_oc_source
(
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [7:0] pulseLen,
	output logic            overcurrentRaw
);
	logic [7:0] left_r = 8'h00;
	always_ff @(posedge clk)
	begin
		if (start)
			left_r <= pulseLen;
		else if (left_r != 8'h00)
			left_r <= left_r - 8'h01;
	end
	assign overcurrentRaw = (left_r != 8'h00);
endmodule : lsf_oc_source

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import lsf_pkg::*;
;
	logic        clk = 0, reset = 1, rd = 0, wr = 0, start = 0, oth = 0;
	logic        en = 1;
	logic [7:0]  addr = 8'h00, len = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic        wreq, oc, swOn, shut, irq, pinN;
	logic [15:0] q;
	int          errors = 0, checked = 0;
	always #10 clk = ~clk;
	lsf_oc_source src_u (.clk(clk), .start(start), .pulseLen(len),
		.overcurrentRaw(oc));
	// Four cycles, so a three-cycle surge must be filtered out
	lsf_fault_response #(.PERSIST(4)) dut_u (.clk(clk), .reset(reset),
		.clkEn(en), .avsAddress(addr), .avsRead(rd), .avsWrite(wr),
		.avsWriteData(wdat), .avsByteEnable(4'hF), .avsReadData(rdat),
		.avsWaitRequest(wreq), .overcurrentRaw(oc),
		.otherSupplyFault(oth), .switchOn(swOn), .shutdownReq(shut),
		.overcurrentTopIrq(irq), .supplyFaultN(pinN));
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] s);
		checked++;
		if (s !== exp)
		begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, s);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdat <= {16'h0000, d};
		// No local limit: the watchdog ends a hung wait
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdat[15:0];
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask : bus
	task surge(input logic [7:0] n, input int w);
		len <= n;
		start <= 1;
		@(posedge clk);
		start <= 0;
		repeat (w) @(posedge clk);
	endtask : surge
	task t_reset;
		bus(0, OFS_SW_CONTROL, 0); chk("ctrl", RST_CONTROL, q);
		bus(0, OFS_IRQ_MASK, 0); chk("mask", 16'h0000, q);
		bus(0, OFS_FAULT_MASK, 0); chk("fmask", 16'h0000, q);
		bus(0, OFS_SW_ENABLE, 0); chk("en", RST_SW_ENABLE, q);
		chk("sw off", 0, swOn);
		bus(0, 8'h00, 0); chk("unmapped", 16'h0000, q);
		chk("pin", 1, pinN);
		$display("test reset done");
	endtask : t_reset
	task t_ignore;
		surge(3, 20); chk("surge irq", 0, irq);
		chk("surge pin", 1, pinN);
		surge(30, 12); chk("fault pin", 0, pinN);
		chk("fault irq", 1, irq);
		repeat (30) @(posedge clk);
		chk("held irq", 1, irq);
		chk("pin back", 1, pinN);
		chk("ign shut", 0, shut);
		bus(0, OFS_IRQ_STATUS, 0); chk("stat", 16'h8000, q);
		chk("irq clr", 0, irq);
		bus(0, OFS_IRQ_STATUS, 0); chk("stat2", 16'h0000, q);
		$display("test ignore done");
	endtask : t_ignore
	task t_masks;
		bus(1, OFS_IRQ_MASK, 16'h8000);
		bus(1, OFS_FAULT_MASK, 16'h8000);
		surge(30, 12); chk("m irq", 0, irq);
		chk("m pin", 1, pinN);
		repeat (30) @(posedge clk);
		bus(1, OFS_IRQ_MASK, 16'h0000);
		chk("unm irq", 1, irq);
		bus(0, OFS_IRQ_STATUS, 0); chk("m stat", 16'h8000, q);
		oth <= 1;
		repeat (8) @(posedge clk);
		chk("other", 0, pinN);
		oth <= 0;
		repeat (8) @(posedge clk);
		chk("other off", 1, pinN);
		$display("test masks done");
	endtask : t_masks
	task t_open;
		bus(1, OFS_SW_ENABLE, 16'h8000);
		bus(0, OFS_SW_ENABLE, 0); chk("en rw", 16'h8000, q);
		chk("sw on", 1, swOn);
		bus(1, OFS_SW_CONTROL, 16'h4003);
		// Frozen block must miss the whole fault
		en <= 0;
		surge(30, 40); chk("frozen", 1, swOn);
		en <= 1;
		surge(30, 14); chk("opened", 0, swOn);
		chk("open shut", 0, shut);
		bus(0, OFS_SW_ENABLE, 0); chk("en clr", 16'h0000, q);
		repeat (30) @(posedge clk);
		chk("still off", 0, swOn);
		bus(1, OFS_SW_ENABLE, 16'h8000);
		chk("re on", 1, swOn);
		$display("test open done");
	endtask : t_open
	task t_shutdown;
		bus(1, OFS_SW_CONTROL, 16'hC003);
		bus(0, OFS_SW_CONTROL, 0); chk("ctrl rw", 16'hC003, q);
		chk("pre shut", 0, shut);
		surge(30, 14); chk("shut", 1, shut);
		repeat (30) @(posedge clk);
		chk("shut held", 1, shut);
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		chk("shut rst", 0, shut);
		bus(0, OFS_SW_CONTROL, 0); chk("ctrl rst", RST_CONTROL, q);
		$display("test shutdown done");
	endtask : t_shutdown
	task conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		t_reset();
		t_ignore();
		t_masks();
		t_open();
		t_shutdown();
		conclude();
	end
	// Whole sequence needs well under 1000 cycles
	initial
	begin
		#100000;
		errors++;
		conclude();
	end
endmodule : tb_top
